// File: core/blcr_defines.vh
`ifndef BLCR_DEFINES_VH
`define BLCR_DEFINES_VH

// Register offsets
`define BLCR_ADDR_LED_CTRL 8'h26
`define BLCR_ADDR_BOOST_CFG 8'h27
`define BLCR_ADDR_GROUP_CUR 8'h28
`define BLCR_ADDR_CH2_CUR 8'h29
`define BLCR_ADDR_CH3_CUR 8'h2A

// Reset values
`define BLCR_RST_LED_CTRL 8'h00
`define BLCR_RST_BOOST_CFG 8'h00
`define BLCR_RST_GROUP_CUR 8'h00
`define BLCR_RST_CH2_CUR 8'h00
`define BLCR_RST_CH3_CUR 8'h00

// Writable bit masks; all other bits are unused and read zero
`define BLCR_MASK_LED_CTRL 8'h01
`define BLCR_MASK_BOOST_CFG 8'h0D
`define BLCR_MASK_GROUP_CUR 8'h3F
`define BLCR_MASK_CH_CUR 8'hBF

// Field positions
`define BLCR_GROUP_EN_BIT 0
`define BLCR_OVP_MSB 3
`define BLCR_OVP_LSB 2
`define BLCR_IPK_BIT 0
`define BLCR_CODE_MSB 5
`define BLCR_CODE_LSB 0
`define BLCR_GROUP_SEL_BIT 7

// Overvoltage threshold codes and levels in millivolts
`define BLCR_OVP_18V5 2'h0
`define BLCR_OVP_15V 2'h1
`define BLCR_OVP_10V 2'h2
`define BLCR_OVP_5V6 2'h3
`define BLCR_OVP_MV_18V5 15'h4844
`define BLCR_OVP_MV_15V 15'h3A98
`define BLCR_OVP_MV_10V 15'h2710
`define BLCR_OVP_MV_5V6 15'h15E0

// Peak current limit levels in milliamps
`define BLCR_IPK_MA_HIGH 10'h258
`define BLCR_IPK_MA_LOW 10'h12C

// Square-law current: full scale 20000 uA at top code 63
`define BLCR_FULL_SCALE_UA 20000
`define BLCR_TOP_CODE 63

`endif

// File: core/blcr_current_lut.v
`timescale 1ns/10ps
`default_nettype none
`include "blcr_defines.vh"

// Square-law code to sink current in microamps, registered output
module blcr_current_lut #(
  parameter CODE_W = 6,
  parameter UA_W = 15
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Code in, current out
  input wire [CODE_W-1:0] code,
  output reg [UA_W-1:0] current_ua
);

  wire [31:0] code_sq;
  wire [31:0] scaled;

  assign code_sq = {{(32-CODE_W){1'b0}}, code} * {{(32-CODE_W){1'b0}}, code};
  // Truncating divide lands exactly on the tabulated figures
  assign scaled = (code_sq * `BLCR_FULL_SCALE_UA) /
    (`BLCR_TOP_CODE * `BLCR_TOP_CODE);

  always @(posedge clk) begin
    if (rst) begin
      current_ua <= {UA_W{1'b0}};
    end else begin
      current_ua <= scaled[UA_W-1:0]; // R05
    end
  end

endmodule // blcr_current_lut

`default_nettype wire

// File: core/blcr_regs.v
// What this block does
// R01: Two-bit overvoltage threshold, four levels, reset zero
// R02: Peak current limit bit: 600 or 300 mA
// R03: Six-bit grouped current code, reset zero
// R04: Grouped channels follow the shared grouped code
// R05: Codes map square-law over 64 levels
// R06: Channel two top bit joins grouped backlight
// R07: Channel three top bit joins grouped backlight
// R08: Channel two own code used only individually
// R09: Channel three own code used only individually
// R10: Grouped current delivered only while enabled
// R11: Unused bits read zero, ignore writes
`timescale 1ns/10ps
`default_nettype none
`include "blcr_defines.vh"

module blcr_regs #(
  parameter CODE_W = 6,
  parameter UA_W = 15
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port behind the serial interface
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Boost protection settings
  output reg [1:0] boost_overvoltage_threshold,
  output reg [14:0] boost_ovp_mv,
  output reg boost_peak_current_limit,
  output reg [9:0] boost_peak_limit_ma,
  // Grouped backlight, drives the first LED channel
  output reg grouped_backlight_enable,
  output reg [CODE_W-1:0] first_led_channel_code,
  output wire [UA_W-1:0] first_led_channel_ua,
  // Channel two
  output reg channel_two_group_select,
  output reg [CODE_W-1:0] channel_two_code,
  output wire [UA_W-1:0] channel_two_ua,
  // Channel three
  output reg channel_three_group_select,
  output reg [CODE_W-1:0] channel_three_code,
  output wire [UA_W-1:0] channel_three_ua
);

  reg [7:0] led_ctrl_reg;
  reg [7:0] boost_cfg_reg;
  reg [7:0] grouped_backlight_current_reg;
  reg [7:0] channel_two_current_reg;
  reg [7:0] channel_three_current_reg;
  reg [7:0] rdata_next;
  reg [14:0] ovp_mv_next;

  wire group_en;
  wire [CODE_W-1:0] grouped_current_code;
  wire [CODE_W-1:0] channel_two_current_code;
  wire [CODE_W-1:0] channel_three_current_code;
  wire [CODE_W-1:0] group_live_code;
  wire [CODE_W-1:0] ch2_next;
  wire [CODE_W-1:0] ch3_next;
  wire [1:0] ovp_field;

  // Register writes; masks keep unused bits at zero
  always @(posedge clk) begin
    if (rst) begin
      led_ctrl_reg <= `BLCR_RST_LED_CTRL;
      boost_cfg_reg <= `BLCR_RST_BOOST_CFG; // R01 R02
      grouped_backlight_current_reg <= `BLCR_RST_GROUP_CUR; // R03
      channel_two_current_reg <= `BLCR_RST_CH2_CUR; // R06 R08
      channel_three_current_reg <= `BLCR_RST_CH3_CUR; // R07 R09
    end else if (reg_wr) begin
      case (reg_addr)
        `BLCR_ADDR_LED_CTRL: begin
          led_ctrl_reg <= reg_wdata & `BLCR_MASK_LED_CTRL; // R11
        end
        `BLCR_ADDR_BOOST_CFG: begin
          boost_cfg_reg <= reg_wdata & `BLCR_MASK_BOOST_CFG; // R11
        end
        `BLCR_ADDR_GROUP_CUR: begin
          grouped_backlight_current_reg <=
            reg_wdata & `BLCR_MASK_GROUP_CUR; // R11
        end
        `BLCR_ADDR_CH2_CUR: begin
          channel_two_current_reg <= reg_wdata & `BLCR_MASK_CH_CUR; // R11
        end
        `BLCR_ADDR_CH3_CUR: begin
          channel_three_current_reg <= reg_wdata & `BLCR_MASK_CH_CUR; // R11
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped offsets answer zero
  always @* begin
    case (reg_addr)
      `BLCR_ADDR_LED_CTRL: rdata_next = led_ctrl_reg;
      `BLCR_ADDR_BOOST_CFG: rdata_next = boost_cfg_reg;
      `BLCR_ADDR_GROUP_CUR: rdata_next = grouped_backlight_current_reg;
      `BLCR_ADDR_CH2_CUR: rdata_next = channel_two_current_reg;
      `BLCR_ADDR_CH3_CUR: rdata_next = channel_three_current_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next; // R11
      end
    end
  end

  // Field extraction
  assign group_en = led_ctrl_reg[`BLCR_GROUP_EN_BIT];
  assign grouped_current_code =
    grouped_backlight_current_reg[`BLCR_CODE_MSB:`BLCR_CODE_LSB];
  assign channel_two_current_code =
    channel_two_current_reg[`BLCR_CODE_MSB:`BLCR_CODE_LSB];
  assign channel_three_current_code =
    channel_three_current_reg[`BLCR_CODE_MSB:`BLCR_CODE_LSB];
  assign ovp_field = boost_cfg_reg[`BLCR_OVP_MSB:`BLCR_OVP_LSB];

  // Grouped code forced to zero while the group is off
  assign group_live_code =
    group_en ? grouped_current_code : {CODE_W{1'b0}}; // R10

  // A grouped channel ignores its own code entirely
  assign ch2_next = channel_two_current_reg[`BLCR_GROUP_SEL_BIT] ?
    group_live_code : channel_two_current_code; // R04 R06 R08
  assign ch3_next = channel_three_current_reg[`BLCR_GROUP_SEL_BIT] ?
    group_live_code : channel_three_current_code; // R04 R07 R09

  // Threshold decode
  always @* begin
    case (ovp_field)
      `BLCR_OVP_18V5: ovp_mv_next = `BLCR_OVP_MV_18V5; // R01
      `BLCR_OVP_15V: ovp_mv_next = `BLCR_OVP_MV_15V; // R01
      `BLCR_OVP_10V: ovp_mv_next = `BLCR_OVP_MV_10V; // R01
      `BLCR_OVP_5V6: ovp_mv_next = `BLCR_OVP_MV_5V6; // R01
      default: ovp_mv_next = `BLCR_OVP_MV_18V5;
    endcase
  end

  // Registered setting outputs, one cycle behind the registers
  always @(posedge clk) begin
    if (rst) begin
      boost_overvoltage_threshold <= 2'h0;
      boost_ovp_mv <= `BLCR_OVP_MV_18V5;
      boost_peak_current_limit <= 1'b0;
      boost_peak_limit_ma <= `BLCR_IPK_MA_HIGH;
      grouped_backlight_enable <= 1'b0;
      first_led_channel_code <= {CODE_W{1'b0}};
      channel_two_group_select <= 1'b0;
      channel_two_code <= {CODE_W{1'b0}};
      channel_three_group_select <= 1'b0;
      channel_three_code <= {CODE_W{1'b0}};
    end else begin
      boost_overvoltage_threshold <= ovp_field; // R01
      boost_ovp_mv <= ovp_mv_next; // R01
      boost_peak_current_limit <= boost_cfg_reg[`BLCR_IPK_BIT]; // R02
      boost_peak_limit_ma <= boost_cfg_reg[`BLCR_IPK_BIT] ?
        `BLCR_IPK_MA_LOW : `BLCR_IPK_MA_HIGH; // R02
      grouped_backlight_enable <= group_en; // R10
      first_led_channel_code <= group_live_code; // R03 R10
      channel_two_group_select <=
        channel_two_current_reg[`BLCR_GROUP_SEL_BIT]; // R06
      channel_two_code <= ch2_next; // R08
      channel_three_group_select <=
        channel_three_current_reg[`BLCR_GROUP_SEL_BIT]; // R07
      channel_three_code <= ch3_next; // R09
    end
  end

  // One converter per sink; adds a further cycle of latency
  blcr_current_lut #(
    .CODE_W(CODE_W),
    .UA_W(UA_W)
  ) u_lut_group (
    .clk(clk),
    .rst(rst),
    .code(first_led_channel_code),
    .current_ua(first_led_channel_ua)
  );

  blcr_current_lut #(
    .CODE_W(CODE_W),
    .UA_W(UA_W)
  ) u_lut_ch2 (
    .clk(clk),
    .rst(rst),
    .code(channel_two_code),
    .current_ua(channel_two_ua)
  );

  blcr_current_lut #(
    .CODE_W(CODE_W),
    .UA_W(UA_W)
  ) u_lut_ch3 (
    .clk(clk),
    .rst(rst),
    .code(channel_three_code),
    .current_ua(channel_three_ua)
  );

endmodule // blcr_regs

`default_nettype wire

// File: tb/blcr_regs_sva.sv
`timescale 1ns/10ps
`default_nettype none
module blcr_regs_sva #(
  parameter CODE_W = 6,
  parameter UA_W = 15
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Settings
  input wire logic [1:0] boost_overvoltage_threshold,
  input wire logic [14:0] boost_ovp_mv,
  input wire logic boost_peak_current_limit,
  input wire logic [9:0] boost_peak_limit_ma,
  input wire logic grouped_backlight_enable,
  input wire logic [CODE_W-1:0] first_led_channel_code,
  input wire logic [UA_W-1:0] first_led_channel_ua,
  input wire logic channel_two_group_select,
  input wire logic [CODE_W-1:0] channel_two_code,
  input wire logic channel_three_group_select,
  input wire logic [CODE_W-1:0] channel_three_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_unmap;
    reg_rd && (reg_addr < 8'h26 || reg_addr > 8'h2A)
      |=> reg_rvalid && reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // Register lands on the write edge, the setting output one edge later
  property p_ovp_wr;
    reg_wr && reg_addr == 8'h27 |-> ##2
      boost_overvoltage_threshold == $past(reg_wdata[3:2], 2) &&
      boost_peak_current_limit == $past(reg_wdata[0], 2);
  endproperty
  a_ovp_wr: assert property (p_ovp_wr) else $error("boost cfg");
  property p_mv;
    boost_ovp_mv == (boost_overvoltage_threshold == 2'h0 ? 15'h4844 :
      boost_overvoltage_threshold == 2'h1 ? 15'h3A98 :
      boost_overvoltage_threshold == 2'h2 ? 15'h2710 : 15'h15E0);
  endproperty
  a_mv: assert property (p_mv) else $error("ovp level");
  property p_ma;
    boost_peak_limit_ma == (boost_peak_current_limit ? 10'h12C : 10'h258);
  endproperty
  a_ma: assert property (p_ma) else $error("peak limit");
  property p_grp;
    reg_wr && reg_addr == 8'h28 ##2 grouped_backlight_enable
      |-> first_led_channel_code == $past(reg_wdata[5:0], 2);
  endproperty
  a_grp: assert property (p_grp) else $error("grouped code");
  property p_off;
    !grouped_backlight_enable |-> first_led_channel_code == 6'h00;
  endproperty
  a_off: assert property (p_off) else $error("group off");
  property p_ch2;
    channel_two_group_select |-> channel_two_code == first_led_channel_code;
  endproperty
  a_ch2: assert property (p_ch2) else $error("ch2 grouped");
  property p_ch3;
    channel_three_group_select
      |-> channel_three_code == first_led_channel_code;
  endproperty
  a_ch3: assert property (p_ch3) else $error("ch3 grouped");
  property p_ind2;
    reg_wr && reg_addr == 8'h29 && !reg_wdata[7]
      |-> ##2 channel_two_code == $past(reg_wdata[5:0], 2);
  endproperty
  a_ind2: assert property (p_ind2) else $error("ch2 own code");
  property p_ind3;
    reg_wr && reg_addr == 8'h2A && !reg_wdata[7]
      |-> ##2 channel_three_code == $past(reg_wdata[5:0], 2);
  endproperty
  a_ind3: assert property (p_ind3) else $error("ch3 own code");
  property p_full;
    first_led_channel_code == 6'h3F |=> first_led_channel_ua == 15'h4E20;
  endproperty
  a_full: assert property (p_full) else $error("full scale");
endmodule // blcr_regs_sva
bind blcr_regs blcr_regs_sva #(.CODE_W(CODE_W), .UA_W(UA_W)) u_sva (.*);
`default_nettype wire

// File: tb/blcr_host.sv
`timescale 1ns/10ps
`default_nettype none
module blcr_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Idle lines show inverted data so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      ok = (reg_rvalid === 1'b1);
      d = reg_rdata;
      if (!ok) @(posedge clk);
    end
  endtask
endmodule // blcr_host
`default_nettype wire

// File: tb/blcr_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module blcr_regs_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, reg_rvalid, boost_peak_current_limit;
  wire grouped_backlight_enable, channel_two_group_select;
  wire channel_three_group_select;
  wire [1:0] boost_overvoltage_threshold;
  wire [14:0] boost_ovp_mv, first_led_channel_ua, channel_two_ua;
  wire [14:0] channel_three_ua;
  wire [9:0] boost_peak_limit_ma;
  wire [5:0] first_led_channel_code, channel_two_code, channel_three_code;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] d;
  logic ok;
  logic [7:0] msk [5] = '{8'h01, 8'h0D, 8'h3F, 8'hBF, 8'hBF};
  logic [14:0] mv [4] = '{15'h4844, 15'h3A98, 15'h2710, 15'h15E0};
  logic [5:0] cd [6] = '{6'h00, 6'h01, 6'h02, 6'h3D, 6'h3E, 6'h3F};
  logic [14:0] ua [6] = '{15'h0, 15'h5, 15'h14, 15'h493E, 15'h4BAA,
                          15'h4E20};
  always #25 clk = ~clk;
  blcr_regs dut (.*);
  blcr_host host (.*);
  task cmp(input string n, input logic [14:0] e, input logic [14:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      num_errors++;
      close_out;
    end else
      cmp("rdata", {7'h00, e}, {7'h00, d});
  endtask
  // Current outputs trail the write by two cycles
  task settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rdc(8'(38 + i), 8'h00);
    cmp("mv", 15'h4844, boost_ovp_mv);
    cmp("ma", 15'h0258, {5'h00, boost_peak_limit_ma});
    for (int i = 0; i < 5; i++) begin
      host.wr(8'(38 + i), 8'hFF);
      rdc(8'(38 + i), msk[i]);
    end
    host.wr(8'h2B, 8'hFF);
    rdc(8'h2B, 8'h00);
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h27, {4'h0, k[1:0], 1'b0, k[0]});
      settle;
      cmp("ovp", mv[k], boost_ovp_mv);
      cmp("ipk", k[0] ? 15'h12C : 15'h258, {5'h0, boost_peak_limit_ma});
    end
    // Own codes stay 3F, so a grouped channel using them shows up here
    for (int k = 0; k < 6; k++) begin
      host.wr(8'h28, {2'h0, cd[k]});
      settle;
      cmp("grp", ua[k], first_led_channel_ua);
      cmp("ch2", ua[k], channel_two_ua);
      cmp("ch3", ua[k], channel_three_ua);
    end
    host.wr(8'h26, 8'h00);
    settle;
    cmp("off1", 15'h0, first_led_channel_ua);
    cmp("off2", 15'h0, channel_two_ua);
    cmp("off3", 15'h0, channel_three_ua);
    host.wr(8'h29, 8'h02);
    host.wr(8'h2A, 8'h7D);
    settle;
    cmp("ind2", 15'h14, channel_two_ua);
    cmp("ind3", 15'h493E, channel_three_ua);
    rdc(8'h2A, 8'h3D);
    close_out;
  end
endmodule // blcr_regs_tb
`default_nettype wire
